// ### rtl/tws_pkg.sv
// package for the two-wire slave: register map, field positions, reset values, types
// assumes a single core clock domain and a plain strobe register port
package tws_pkg;

   // register indices on the plain register port
   localparam logic [2:0] REG_RCV = 3'h0;
   localparam logic [2:0] REG_TRN = 3'h1;
   localparam logic [2:0] REG_BRG = 3'h2;
   localparam logic [2:0] REG_CON = 3'h3;
   localparam logic [2:0] REG_STAT = 3'h4;
   localparam logic [2:0] REG_ADD = 3'h5;

   // serial_control field positions
   localparam int CON_ENABLE = 15;
   localparam int CON_RELEASE = 12;
   localparam int CON_TENBIT = 10;
   localparam int CON_STRETCH = 6;

   // serial_status field positions
   localparam int STAT_TBF = 0;
   localparam int STAT_RBF = 1;
   localparam int STAT_READ = 2;
   localparam int STAT_OVF = 6;
   localparam int STAT_FULL_ADDRESS_MATCHED = 8;
   localparam int STAT_ADDRD = 9;

   // reset values
   localparam logic [15:0] CON_RST = 16'h1000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [8:0] BRG_RST = 9'h000;
   localparam logic [9:0] ADD_RST = 10'h000;

   // address and framing constants
   localparam logic [4:0] TEN_PREFIX = 5'h1E;
   localparam logic [6:0] ADDR7_LO = 7'h04;
   localparam logic [6:0] ADDR7_HI = 7'h77;
   localparam logic [3:0] BITS_BYTE = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADR1 = 3'h1,
      ST_ADR2 = 3'h2,
      ST_RX = 3'h3,
      ST_TX = 3'h4,
      ST_ACK_OUT = 3'h5,
      ST_ACK_IN = 3'h6
   } tws_state_e;

   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tws_req_s;

endpackage

// ### rtl/tws_slave.sv
// two-wire bus slave: address match, byte receive, byte transmit, clock stretch
// assumes an external master on open-drain lines with pull-ups, and software on
// the plain register port in the core_clk domain

// Summary of operation
// - 7-bit mode compares address bits 6:0 with byte bits 7:1; bit 0 is direction.
// - every data bit is sampled on a rising serial clock edge.
// - when enabled, idle until Start, then shift eight bits for address compare.
// - on match acknowledge, then pulse slave event on the ninth falling edge.
// - address match leaves receive buffer and buffer-full flag untouched.
// - read direction enters transmit, acknowledges, and with transmit buffer empty holds clock low until software sets clock release.
// - transmit bits change after falling clock edges, stable while clock high.
// - transmit pulses the event on the ninth falling edge, ack or not.
// - receive moves completed byte into buffer when empty and acknowledges if overflow is clear.
// - buffer full on completion: no ack, keep old byte, still pulse event.
// - overflow set but buffer empty: load the byte but withhold acknowledge.
// - ten-bit select off means 7-bit address, on means full 10-bit address.
// - 10-bit first byte compares 11110 prefix and two top address bits.
// - first byte write match pulses, clears full-match flag; else clear and idle.
// - second byte compares low eight bits; match pulses and sets full-match flag.
// - after Repeated Start following full match, a read first byte alone suffices.
// - 7-bit addresses 0x04-0x77 ordinary; 0x78-0x7b are ten-bit prefixes.
// - transmit with an empty buffer stretches the clock regardless of stretch enable.
// - ack sampled with transmit buffer empty clears clock release, holding clock low.
// - transmit byte written before ninth fall: no release clear, no stretch.
// - software may set clock release at any time.
module tws_slave
   import tws_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // register port
   input wire tws_req_s reg_req,
   output logic [15:0] reg_rdata,
   // serial clock line
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   // serial data line
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // event
   output logic slave_event
);

   ////////////////////////////////////////////////////////////////////////////
   // line synchronisers and edge detection

   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   assign scl_s = scl_sync_q[1];
   assign sda_s = sda_sync_q[1];
   // edges of the master clock as seen from the core clock
   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // software registers

   logic [15:0] con_q;
   logic [7:0] trn_q;
   logic [7:0] rcv_q;
   logic [8:0] brg_q;
   logic [9:0] add_q;
   logic tbf_q;
   logic rbf_q;
   logic ovf_q;
   logic full_address_matched_q;
   logic addrd_q;
   logic read_q;
   logic rel_q;
   logic [15:0] rdata_q;
   logic wr_con;
   logic wr_trn;
   logic wr_stat;
   logic rd_rcv;
   logic enable;
   logic tenbit;
   logic tbf_eff;
   logic [7:0] trn_eff;

   assign wr_con = reg_req.wr & (reg_req.addr == REG_CON);
   assign wr_trn = reg_req.wr & (reg_req.addr == REG_TRN);
   assign wr_stat = reg_req.wr & (reg_req.addr == REG_STAT);
   assign rd_rcv = reg_req.rd & (reg_req.addr == REG_RCV);
   assign enable = con_q[CON_ENABLE];
   assign tenbit = con_q[CON_TENBIT];
   // a byte written in the same cycle as a load is taken, not lost
   assign tbf_eff = tbf_q | wr_trn;
   assign trn_eff = wr_trn ? reg_req.wdata[7:0] : trn_q;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         con_q <= CON_RST;
         trn_q <= BYTE_RST;
         brg_q <= BRG_RST;
         add_q <= ADD_RST;
      end else begin
         if (wr_con) begin
            con_q <= reg_req.wdata;
         end
         if (wr_trn) begin
            trn_q <= reg_req.wdata[7:0];
         end
         if (reg_req.wr && reg_req.addr == REG_BRG) begin
            brg_q <= reg_req.wdata[8:0];
         end
         if (reg_req.wr && reg_req.addr == REG_ADD) begin
            add_q <= reg_req.wdata[9:0];
         end
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 16'h0000;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            REG_RCV: rdata_q <= {8'h00, rcv_q};
            REG_TRN: rdata_q <= {8'h00, trn_q};
            REG_BRG: rdata_q <= {7'h00, brg_q};
            REG_CON: begin
               rdata_q <= con_q;
               rdata_q[CON_RELEASE] <= rel_q;
            end
            REG_STAT: begin
               rdata_q <= 16'h0000;
               rdata_q[STAT_TBF] <= tbf_q;
               rdata_q[STAT_RBF] <= rbf_q;
               rdata_q[STAT_READ] <= read_q;
               rdata_q[STAT_OVF] <= ovf_q;
               rdata_q[STAT_FULL_ADDRESS_MATCHED] <= full_address_matched_q;
               rdata_q[STAT_ADDRD] <= addrd_q;
            end
            REG_ADD: rdata_q <= {6'h00, add_q};
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // byte decision at the eighth falling edge

   tws_state_e state_q;
   tws_state_e nxt_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] tx_sh_q;
   logic ack_q;
   logic evt_q;
   logic mack_q;
   logic pend_q;
   logic byte_state;
   logic eval_fire;
   logic match7;
   logic match10hi;
   logic dec_ack;
   logic dec_evt;
   logic dec_load;
   logic dec_ovf;
   logic dec_a10_set;
   logic dec_a10_clr;
   tws_state_e dec_nxt;

   assign byte_state = (state_q == ST_ADR1) | (state_q == ST_ADR2) | (state_q == ST_RX);
   assign eval_fire = enable & byte_state & scl_fall & (cnt_q == BITS_BYTE);
   // only the ordinary 7-bit range can match; the prefix range never does
   assign match7 = (sh_q[7:1] == add_q[6:0]) & (add_q[6:0] >= ADDR7_LO)
                 & (add_q[6:0] <= ADDR7_HI);
   assign match10hi = (sh_q[7:3] == TEN_PREFIX) & (sh_q[2:1] == add_q[9:8]);

   always_comb begin
      dec_ack = 1'b0;
      dec_evt = 1'b0;
      dec_load = 1'b0;
      dec_ovf = 1'b0;
      dec_a10_set = 1'b0;
      dec_a10_clr = 1'b0;
      dec_nxt = ST_IDLE;
      if (state_q == ST_ADR1) begin
         if (!tenbit) begin
            if (match7) begin
               dec_ack = 1'b1;
               dec_evt = 1'b1;
               dec_nxt = sh_q[0] ? ST_TX : ST_RX;
            end
         end else if (match10hi && !sh_q[0]) begin
            dec_ack = 1'b1;
            dec_evt = 1'b1;
            dec_a10_clr = 1'b1;
            dec_nxt = ST_ADR2;
         end else if (match10hi && addrd_q) begin
            dec_ack = 1'b1;
            dec_evt = 1'b1;
            dec_nxt = ST_TX;
         end else begin
            dec_a10_clr = 1'b1;
         end
      end else if (state_q == ST_ADR2) begin
         if (sh_q == add_q[7:0]) begin
            dec_ack = 1'b1;
            dec_evt = 1'b1;
            dec_a10_set = 1'b1;
            dec_nxt = ST_RX;
         end else begin
            dec_a10_clr = 1'b1;
         end
      end else if (state_q == ST_RX) begin
         dec_evt = 1'b1;
         dec_nxt = ST_RX;
         if (!rbf_q) begin
            dec_load = 1'b1;
            dec_ack = ~ovf_q;
         end else begin
            dec_ovf = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit sequencer

   logic ack_out_fall;
   logic ack_in_fall;
   logic tx_begin;
   logic tx_load;
   logic tx_stall;

   assign ack_out_fall = enable & (state_q == ST_ACK_OUT) & scl_fall & ~bus_start & ~bus_stop;
   assign ack_in_fall = enable & (state_q == ST_ACK_IN) & scl_fall & ~bus_start & ~bus_stop;
   assign tx_begin = (ack_out_fall & ack_q & (nxt_q == ST_TX)) | (ack_in_fall & mack_q);
   // nothing to send yet: stretch, and take the byte once software loads it
   assign tx_load = (tx_begin | pend_q) & tbf_eff;
   assign tx_stall = tx_begin & ~tbf_eff;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= BYTE_RST;
         ack_q <= 1'b0;
         evt_q <= 1'b0;
         mack_q <= 1'b0;
      end else if (!enable) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (bus_start) begin
         state_q <= ST_ADR1;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (bus_stop) begin
         state_q <= ST_IDLE;
         ack_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               cnt_q <= 4'h0;
            end
            ST_ADR1, ST_ADR2, ST_RX: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end else if (eval_fire) begin
                  ack_q <= dec_ack;
                  evt_q <= dec_evt;
                  nxt_q <= dec_nxt;
                  state_q <= ST_ACK_OUT;
                  cnt_q <= 4'h0;
               end
            end
            ST_ACK_OUT: begin
               if (scl_fall) begin
                  ack_q <= 1'b0;
                  state_q <= ack_q ? nxt_q : ST_IDLE;
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BITS_BYTE) begin
                  state_q <= ST_ACK_IN;
                  cnt_q <= 4'h0;
               end
            end
            ST_ACK_IN: begin
               if (scl_rise) begin
                  mack_q <= ~sda_s;
               end else if (scl_fall) begin
                  state_q <= mack_q ? ST_TX : ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // transmit shifter: next bit presented after each falling edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_sh_q <= 8'hFF;
         pend_q <= 1'b0;
      end else if (!enable || bus_start || bus_stop) begin
         tx_sh_q <= 8'hFF;
         pend_q <= 1'b0;
      end else if (tx_load) begin
         tx_sh_q <= trn_eff;
         pend_q <= 1'b0;
      end else if (tx_stall) begin
         pend_q <= 1'b1;
      end else if (state_q == ST_TX && scl_fall && cnt_q < BITS_BYTE) begin
         tx_sh_q <= {tx_sh_q[6:0], 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rcv_q <= BYTE_RST;
      end else if (eval_fire && dec_load) begin
         rcv_q <= sh_q;
      end
   end

   // hardware set wins over the software clear in the same cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rbf_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         if (eval_fire && dec_load) begin
            rbf_q <= 1'b1;
         end else if (rd_rcv) begin
            rbf_q <= 1'b0;
         end
         if (eval_fire && dec_ovf) begin
            ovf_q <= 1'b1;
         end else if (wr_stat && !reg_req.wdata[STAT_OVF]) begin
            ovf_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tbf_q <= 1'b0;
      end else if (wr_trn) begin
         tbf_q <= ~tx_load;
      end else if (tx_load) begin
         tbf_q <= 1'b0;
      end
   end

   // addrd_q survives a repeated start, ends with stop or disable; the full-match flag outlasts both
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         full_address_matched_q <= 1'b0;
         addrd_q <= 1'b0;
      end else if (!enable || bus_stop) begin
         addrd_q <= 1'b0;
      end else if (eval_fire && dec_a10_set) begin
         full_address_matched_q <= 1'b1;
         addrd_q <= 1'b1;
      end else if (eval_fire && dec_a10_clr) begin
         full_address_matched_q <= 1'b0;
         addrd_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         read_q <= 1'b0;
      end else if (eval_fire && dec_ack) begin
         read_q <= (dec_nxt == ST_TX);
      end else if (bus_stop || !enable) begin
         read_q <= 1'b0;
      end
   end

   // software set wins over the automatic clear; software clear only with stretch enabled
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rel_q <= CON_RST[CON_RELEASE];
      end else if (wr_con && reg_req.wdata[CON_RELEASE]) begin
         rel_q <= 1'b1;
      end else if (tx_stall) begin
         rel_q <= 1'b0;
      end else if (wr_con && con_q[CON_STRETCH]) begin
         rel_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line drivers and event

   logic hold_q;
   logic sda_oe_q;
   logic event_q;

   // the clock is only pulled once it is seen low, so high time is never cut
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_q <= 1'b0;
      end else if (rel_q || !enable) begin
         hold_q <= 1'b0;
      end else if (!scl_s) begin
         hold_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sda_oe_q <= 1'b0;
      end else begin
         sda_oe_q <= enable & (((state_q == ST_ACK_OUT) & ack_q)
                   | ((state_q == ST_TX) & ~tx_sh_q[7]));
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         event_q <= 1'b0;
      end else begin
         event_q <= (ack_out_fall & evt_q) | ack_in_fall;
      end
   end

   // open drain: the lines are only ever pulled low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = hold_q;
   assign sda_oe = sda_oe_q;
   assign slave_event = event_q;

endmodule

// ### tb/tws_slave_properties.sv
// checker for the two-wire slave, watching the top ports only
// assumes pull-ups on both lines and the single core clock domain
module tws_slave_props
   import tws_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // register port
   input wire tws_req_s reg_req,
   input wire logic [15:0] reg_rdata,
   // lines
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // event
   input wire logic slave_event
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////
   logic rel_wr;
   logic en_q;
   assign rel_wr = reg_req.wr && reg_req.addr == REG_CON && reg_req.wdata[CON_RELEASE];
   // enable mirror, so a quiet bus can be told from a dead one
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         en_q <= 1'b0;
      end else if (reg_req.wr && reg_req.addr == REG_CON) begin
         en_q <= reg_req.wdata[CON_ENABLE];
      end
   end
   open_drain_a: assert property (!scl_o && !sda_o)
      else $error("line driven high");
   event_pulse_a: assert property (slave_event |=> !slave_event)
      else $error("event longer than a cycle");
   event_after_fall_a: assert property (
      slave_event |-> !scl_i && !$past(scl_i) && !$past(scl_i, 2))
      else $error("event outside clock low phase");
   sda_change_low_a: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data changed while clock high");
   stretch_on_low_a: assert property ($rose(scl_oe) |-> !$past(scl_i, 2))
      else $error("stretch began in high phase");
   release_write_a: assert property (scl_oe && rel_wr |-> ##[1:3] !scl_oe)
      else $error("release write ignored");
   stretch_end_a: assert property (
      $fell(scl_oe) |-> $past(rel_wr) || $past(rel_wr, 2) || $past(rel_wr, 3))
      else $error("clock freed without release");
   disabled_quiet_a: assert property (!en_q && !$past(en_q) |-> !sda_oe && !scl_oe)
      else $error("disabled slave drives a line");
   cover property (slave_event);
   cover property ($rose(scl_oe));
   cover property ($fell(sda_oe) && !scl_i);
endmodule

// ### tb/tws_bus_master.sv
// behavioural two-wire bus master
// assumes wired-and lines with pull-ups in the bench top
module tws_bus_master (
   // line levels
   input wire logic scl_w,
   input wire logic sda_w,
   // pull-downs, 1 = released
   output logic scl_m,
   output logic sda_m
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // one clock; low phase waits out a stretching slave
   task automatic pulse(input logic b, output logic s);
      int n;
      #20 sda_m = b;
      #50 scl_m = 1'b1;
      n = 0;
      while (scl_w !== 1'b1 && n < 5000) begin
         #10 n++;
      end
      s = sda_w;
      #55 scl_m = 1'b0;
   endtask
   task automatic start_cond();
      #20 sda_m = 1'b1;
      #50 scl_m = 1'b1;
      #30 sda_m = 1'b0;
      #40 scl_m = 1'b0;
   endtask
   task automatic stop_cond();
      #20 sda_m = 1'b0;
      #50 scl_m = 1'b1;
      #30 sda_m = 1'b1;
      #60;
   endtask
   // msb first, ninth clock carries the ack
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         pulse(d[i], s);
      end
      pulse(1'b1, s);
      ack = !s;
   endtask
   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b1, d[i]);
      end
      pulse(!ack, s);
   endtask
endmodule

// ### tb/tws_slave_test.sv
// self-checking bench for the two-wire slave
// assumes pull-ups on both lines, modelled here as wired-and
module tws_slave_test
   import tws_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk;
   logic arst_n;
   tws_req_s reg_req;
   logic [15:0] reg_rdata;
   logic scl_o, scl_oe, sda_o, sda_oe, slave_event, scl_m, sda_m, ack;
   logic m_rbf, m_ovf;
   logic [7:0] m_rcv, d;
   logic [6:0] a7;
   logic [9:0] a10;
   logic [15:0] con;
   int mismatches, tests_run, ev_n;
   wire scl_w = scl_m & ~scl_oe;
   wire sda_w = sda_m & ~sda_oe;
   tws_slave tws_slave_i (.core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .slave_event(slave_event));
   tws_bus_master tws_bus_master_i (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
      .sda_m(sda_m));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (slave_event === 1'b1) begin
         ev_n <= ev_n + 1;
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic close_out();
      if (mismatches == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] w);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      reg_req <= '0;
   endtask
   task automatic rdc(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      reg_req <= '0;
      #1;
      chk(reg_rdata & m, e);
   endtask
   function automatic logic [15:0] mstat();
      return (16'(m_ovf) << STAT_OVF) | (16'(m_rbf) << STAT_RBF);
   endfunction
   task automatic addr_byte(input logic st, input logic [7:0] b, input logic e);
      int e0;
      if (st) begin
         tws_bus_master_i.start_cond();
      end
      e0 = ev_n;
      tws_bus_master_i.send_byte(b, ack);
      #100;
      chk(16'(ack), 16'(e));
      chk(16'(ev_n - e0), 16'(e));
   endtask
   // receive model: ack only with buffer and overflow clear
   task automatic rx_byte(input logic [7:0] b);
      int e0;
      e0 = ev_n;
      tws_bus_master_i.send_byte(b, ack);
      #100;
      chk(16'(ack), 16'(!m_rbf && !m_ovf));
      chk(16'(ev_n - e0), 16'h0001);
      if (m_rbf) begin
         m_ovf = 1'b1;
      end else begin
         m_rcv = b;
         m_rbf = 1'b1;
      end
   endtask
   task automatic tx_byte(input logic [7:0] b, input logic a, input logic pre);
      int e0;
      logic [7:0] r;
      if (!pre) begin
         wr(REG_TRN, {8'h00, b});
         wr(REG_CON, con);
      end
      e0 = ev_n;
      tws_bus_master_i.recv_byte(a, r);
      #100;
      chk({8'h00, r}, {8'h00, b});
      chk(16'(ev_n - e0), 16'h0001);
   endtask
   initial begin
      #400000;
      mismatches++;
      close_out();
   end
   initial begin
      arst_n = 1'b0;
      reg_req = '0;
      m_rbf = 1'b0;
      m_ovf = 1'b0;
      m_rcv = 8'h00;
      con = 16'h9000;
      void'($urandom(32'h0789));
      a7 = 7'(7'h04 + $urandom % 116);
      a10 = 10'($urandom);
      d = 8'($urandom);
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      // reset values, access kinds, unmapped index
      rdc(REG_CON, 16'hFFFF, CON_RST);
      rdc(REG_STAT, 16'hFFFF, 16'h0000);
      wr(REG_RCV, 16'h00A5);
      rdc(REG_RCV, 16'hFFFF, 16'h0000);
      wr(REG_BRG, 16'hFFFF);
      rdc(REG_BRG, 16'hFFFF, 16'h01FF);
      wr(3'h7, 16'hFFFF);
      rdc(3'h7, 16'hFFFF, 16'h0000);
      // upper address bits set: 7-bit mode must ignore them
      wr(REG_ADD, {6'h00, a10[9:7], a7});
      rdc(REG_ADD, 16'hFFFF, {6'h00, a10[9:7], a7});
      addr_byte(1'b1, {a7, 1'b0}, 1'b0);
      tws_bus_master_i.stop_cond();
      wr(REG_CON, con);
      addr_byte(1'b1, {a7, 1'b0}, 1'b1);
      rdc(REG_STAT, 16'h0043, mstat());
      rx_byte(d);
      rdc(REG_STAT, 16'h0043, mstat());
      rx_byte(~d);
      tws_bus_master_i.stop_cond();
      rdc(REG_STAT, 16'h0043, mstat());
      rdc(REG_RCV, 16'hFFFF, {8'h00, m_rcv});
      m_rbf = 1'b0;
      addr_byte(1'b1, {a7, 1'b0}, 1'b1);
      rx_byte(d + 8'h5A);
      tws_bus_master_i.stop_cond();
      rdc(REG_RCV, 16'hFFFF, {8'h00, m_rcv});
      m_rbf = 1'b0;
      wr(REG_STAT, 16'h0000);
      m_ovf = 1'b0;
      rdc(REG_STAT, 16'h0043, mstat());
      addr_byte(1'b1, {a7 ^ 7'h01, 1'b0}, 1'b0);
      tws_bus_master_i.stop_cond();
      wr(REG_ADD, 16'h0078);
      addr_byte(1'b1, 8'hF0, 1'b0);
      tws_bus_master_i.stop_cond();
      wr(REG_ADD, {6'h00, a10[9:7], a7});
      // read: stretch while empty, then a byte loaded early
      addr_byte(1'b1, {a7, 1'b1}, 1'b1);
      chk(16'(scl_oe), 16'h0001);
      rdc(REG_STAT, 16'h0005, 16'h0004);
      rdc(REG_CON, 16'h1000, 16'h0000);
      tx_byte(8'($urandom), 1'b1, 1'b0);
      chk(16'(scl_oe), 16'h0001);
      tx_byte(8'($urandom), 1'b0, 1'b0);
      chk(16'(scl_oe), 16'h0000);
      tws_bus_master_i.stop_cond();
      wr(REG_TRN, {8'h00, d});
      rdc(REG_STAT, 16'h0001, 16'h0001);
      addr_byte(1'b1, {a7, 1'b1}, 1'b1);
      chk(16'(scl_oe), 16'h0000);
      rdc(REG_CON, 16'h1000, 16'h1000);
      tx_byte(d, 1'b0, 1'b1);
      tws_bus_master_i.stop_cond();
      // release clear only takes effect once stretch enable is already set
      wr(REG_CON, 16'h8040);
      rdc(REG_CON, 16'h1040, 16'h1040);
      wr(REG_CON, 16'h8040);
      rdc(REG_CON, 16'h1040, 16'h0040);
      wr(REG_CON, con);
      rdc(REG_CON, 16'h1040, 16'h1000);
      // ten-bit addressing
      con = 16'h9400;
      wr(REG_CON, con);
      wr(REG_ADD, {6'h00, a10});
      addr_byte(1'b1, {TEN_PREFIX, a10[9:8], 1'b0}, 1'b1);
      rdc(REG_STAT, 16'h0100, 16'h0000);
      addr_byte(1'b0, a10[7:0], 1'b1);
      rdc(REG_STAT, 16'h0300, 16'h0300);
      rx_byte(d);
      addr_byte(1'b1, {TEN_PREFIX, a10[9:8], 1'b1}, 1'b1);
      chk(16'(scl_oe), 16'h0001);
      tx_byte(8'($urandom), 1'b0, 1'b0);
      tws_bus_master_i.stop_cond();
      rdc(REG_STAT, 16'h0300, 16'h0100);
      addr_byte(1'b1, {TEN_PREFIX, a10[9:8], 1'b1}, 1'b0);
      tws_bus_master_i.stop_cond();
      rdc(REG_STAT, 16'h0100, 16'h0000);
      addr_byte(1'b1, {TEN_PREFIX, a10[9:8], 1'b0}, 1'b1);
      addr_byte(1'b0, ~a10[7:0], 1'b0);
      tws_bus_master_i.stop_cond();
      rdc(REG_STAT, 16'h0100, 16'h0000);
      close_out();
   end
endmodule

bind tws_slave tws_slave_props tws_slave_props_i (.core_clk(core_clk), .arst_n(arst_n),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .slave_event(slave_event));
